//--- logic/usbis_pkg.sv
// package of constants and types for the usb device interrupt status block
//
// Notes on behaviour
// - 32-bit status register, four bytes, at address 18H, read and write.
// - a flag sets on its hardware event and stays set until cleared.
// - interrupt output high while any status bit is set, low when all zero.
// - endpoint flags: ep0 receive at bit 10 up to ep7 transmit at 25.
// - bus reset bit 0, frame 1, pseudo frame 2, suspend 3, resume 4.
// - dma events share one summary flag at bit 6.
// - writing 1 clears a non-dma flag, writing 0 leaves it alone.
// - dma flag clears through a write-1 to the dma reason register or a bus reset, not a status write.
// - control setup flag at bit 8 sets on a setup token on endpoint 0.
// - bit 5 sets on full to high speed change, not on suspend.
// - pseudo frames made inside, 1 ms full speed, 125 us high speed.
// - dma summary flag sets whenever the dma status contents change.
package usbis_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] USBIS_ADDR_STATUS = 8'h18;
  localparam logic [31:0] USBIS_STATUS_RESET = 32'h0000_0000;
  // bits 31..26, 9 and 7 are reserved
  localparam logic [31:0] USBIS_IMPL_MASK = 32'h03FF_FD7F;
  localparam int USBIS_NUM_EP = 8;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int USBIS_BIT_BUS_RESET = 0;
  localparam int USBIS_BIT_FRAME = 1;
  localparam int USBIS_BIT_PSEUDO_FRAME = 2;
  localparam int USBIS_BIT_SUSPEND = 3;
  localparam int USBIS_BIT_RESUME = 4;
  localparam int USBIS_BIT_HIGH_SPEED = 5;
  localparam int USBIS_BIT_DMA = 6;
  localparam int USBIS_BIT_SETUP = 8;
  localparam int USBIS_BIT_EP_BASE = 10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int USBIS_CLK_PERIOD_PS = 5000;
  localparam int USBIS_FS_FRAME_US = 1000;
  localparam int USBIS_HS_FRAME_US = 125;
  localparam int USBIS_FS_FRAME_CYC = USBIS_FS_FRAME_US * 1000000 / USBIS_CLK_PERIOD_PS;
  localparam int USBIS_HS_FRAME_CYC = USBIS_HS_FRAME_US * 1000000 / USBIS_CLK_PERIOD_PS;
  localparam int USBIS_FRAME_CNT_W = 18;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic bus_reset;
    logic frame_marker;
    logic suspend_entry;
    logic resume;
    logic high_speed;
    logic setup_received;
    logic [USBIS_NUM_EP-1:0] ep_receive;
    logic [USBIS_NUM_EP-1:0] ep_transmit;
  } usbis_event_s;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } usbis_bus_s;

endpackage : usbis_pkg

//--- logic/usbis_pseudo_frame.sv
// pseudo frame marker generator locked to received frame markers
`timescale 1ns/100ps
`default_nettype none
module usbis_pseudo_frame
  import usbis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic high_speed,
  input wire logic frame_marker,
  output logic pseudo_tick
);
  logic [USBIS_FRAME_CNT_W-1:0] cnt_r;
  logic [USBIS_FRAME_CNT_W-1:0] cnt_nxt;
  logic [USBIS_FRAME_CNT_W-1:0] period;
  logic tick_r;
  logic tick_nxt;

  // a real marker restarts the count so the internal frame tracks the bus
  always_comb begin
    period = high_speed ? USBIS_FRAME_CNT_W'(USBIS_HS_FRAME_CYC - 1)
                        : USBIS_FRAME_CNT_W'(USBIS_FS_FRAME_CYC - 1);
    tick_nxt = 1'b0;
    if (frame_marker) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else if (cnt_r >= period) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign pseudo_tick = tick_r;
endmodule : usbis_pseudo_frame
`default_nettype wire

//--- logic/usbis_top.sv
// interrupt status register with interrupt request output
`timescale 1ns/100ps
`default_nettype none
module usbis_top
  import usbis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire usbis_pkg::usbis_bus_s bus,
  output logic [31:0] rdata,
  input wire usbis_pkg::usbis_event_s evt,
  input wire logic [15:0] dma_status,
  input wire logic dma_reason_clear,
  output logic irq
);
  import usbis_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [15:0] dma_prev_r;
  logic hs_prev_r;
  logic pseudo_tick;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic wr_hit;

  // ************************************************************
  // pseudo frame source
  // ************************************************************
  usbis_pseudo_frame u_pseudo (
    .clk_sys(clk_sys),
    .rst(rst),
    .high_speed(evt.high_speed),
    .frame_marker(evt.frame_marker),
    .pseudo_tick(pseudo_tick)
  );

  // one decode serves both directions, so reads and writes cannot drift apart
  function automatic logic addr_hit(input usbis_bus_s b, input logic want_wr);
    return b.sel && (b.wr == want_wr) && (b.addr == USBIS_ADDR_STATUS);
  endfunction : addr_hit

  // event set vector and write-one-to-clear vector
  always_comb begin
    wr_hit = addr_hit(bus, 1'b1);
    set_vec = '0;
    set_vec[USBIS_BIT_BUS_RESET] = evt.bus_reset;
    set_vec[USBIS_BIT_FRAME] = evt.frame_marker;
    set_vec[USBIS_BIT_PSEUDO_FRAME] = pseudo_tick;
    set_vec[USBIS_BIT_SUSPEND] = evt.suspend_entry;
    set_vec[USBIS_BIT_RESUME] = evt.resume;
    // only the rising edge of high speed; dropping into suspend never sets it
    set_vec[USBIS_BIT_HIGH_SPEED] = evt.high_speed && !hs_prev_r;
    set_vec[USBIS_BIT_DMA] = (dma_status != dma_prev_r);
    set_vec[USBIS_BIT_SETUP] = evt.setup_received;
    for (int i = 0; i < USBIS_NUM_EP; i++) begin
      set_vec[USBIS_BIT_EP_BASE + 2 * i] = evt.ep_receive[i];
      set_vec[USBIS_BIT_EP_BASE + 2 * i + 1] = evt.ep_transmit[i];
    end
    clr_vec = wr_hit ? bus.wdata : '0;
    clr_vec[USBIS_BIT_DMA] = dma_reason_clear;
  end

  // status next value; set beats clear, reserved bits forced to zero
  always_comb begin
    status_nxt = ((status_r & ~clr_vec) | set_vec) & USBIS_IMPL_MASK;
    // a bus reset wipes the register; its own flag then records it
    if (evt.bus_reset) begin
      status_nxt = '0;
      status_nxt[USBIS_BIT_BUS_RESET] = 1'b1;
    end
    irq_nxt = |status_nxt;
    rdata_nxt = addr_hit(bus, 1'b0) ? status_nxt : '0;
  end

  // registers; edge trackers follow their inputs through reset so that a
  // level already present at release is not mistaken for a fresh change
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_r <= USBIS_STATUS_RESET;
      rdata_r <= '0;
      irq_r <= 1'b0;
      dma_prev_r <= dma_status;
      hs_prev_r <= evt.high_speed;
    end else begin
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      dma_prev_r <= dma_status;
      hs_prev_r <= evt.high_speed;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
endmodule : usbis_top
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the interrupt status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import usbis_pkg::*;
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %0t got %h", $time, a); end end
  typedef struct packed {logic [21:0] ev; logic [31:0] exp;} usbis_row_s;
  logic clk_sys = 0;
  logic rst = 1;
  logic dma_clr = 0;
  logic irq;
  logic [15:0] dma_st = 16'h0000;
  logic [31:0] rdata;
  logic [31:0] q;
  usbis_event_s evt = '0;
  usbis_bus_s bus;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  // one event per row except the last, which raises all sixteen endpoint events; read in the same cycle as the event lands
  usbis_row_s rows [9] = '{'{22'h20_0000, 32'h1}, '{22'h10_0000, 32'h2},
    '{22'h08_0000, 32'h8}, '{22'h04_0000, 32'h10}, '{22'h02_0000, 32'h20},
    '{22'h01_0000, 32'h100}, '{22'h00_0100, 32'h400}, '{22'h00_0080, 32'h200_0000},
    '{22'h00_FFFF, 32'h3FF_FC00}};
  always #2.5 clk_sys = ~clk_sys;
  usbis_top DUT (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .evt(evt),
    .dma_status(dma_st), .dma_reason_clear(dma_clr), .irq(irq));
  usbis_host u_host (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));
  task automatic pulse(input logic [21:0] ev);
    @(posedge clk_sys) evt <= ev;
    @(posedge clk_sys) evt <= '0;
  endtask : pulse
  task automatic rd();
    u_host.acc(1'b0, USBIS_ADDR_STATUS, 32'h0, q);
  endtask : rd
  task automatic wr(input logic [31:0] d);
    u_host.acc(1'b1, USBIS_ADDR_STATUS, d, q);
  endtask : wr
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // hang guard; the high speed frame test alone needs about 25000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 27000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    foreach (rows[i]) begin
      fork
        rd();
        pulse(rows[i].ev);
      join
      `CHK(q, rows[i].exp)
      `CHK(irq, 1'b1)
      wr(32'hFFFF_FFFF);
      rd();
      `CHK(q, 32'h0)
      `CHK(irq, 1'b0)
    end
    $display("table done");
    pulse(22'h01_0100);
    wr(32'h0);
    rd();
    `CHK(q, 32'h500)
    wr(32'h100);
    rd();
    `CHK(q, 32'h400)
    wr(32'h400);
    fork
      wr(32'h10);
      pulse(22'h04_0000);
    join
    rd();
    `CHK(q, 32'h10)
    wr(32'h10);
    $display("clear done");
    @(posedge clk_sys) dma_st <= 16'h0001;
    rd();
    `CHK(q, 32'h40)
    wr(32'h40);
    u_host.acc(1'b0, 8'h1C, 32'h0, q);
    `CHK(q, 32'h0)
    rd();
    `CHK(q, 32'h40)
    @(posedge clk_sys) dma_clr <= 1;
    @(posedge clk_sys) dma_clr <= 0;
    rd();
    `CHK(q, 32'h0)
    $display("dma done");
    // a bus reset wipes flags raised before it
    pulse(22'h00_0100);
    pulse(22'h20_0000);
    rd();
    `CHK(q, 32'h1)
    wr(32'h1);
    $display("bus reset done");
    // hold high speed, lock the pseudo frame to a marker, then time the next tick
    @(posedge clk_sys) evt <= 22'h12_0000;
    @(posedge clk_sys) evt <= 22'h02_0000;
    rd();
    `CHK(q, 32'h26)
    wr(32'hFFFF_FFFF);
    rd();
    `CHK(q, 32'h0)
    repeat (24992) @(posedge clk_sys);
    rd();
    `CHK(q, 32'h0)
    rd();
    `CHK(q, 32'h4)
    @(posedge clk_sys) evt <= '0;
    wr(32'h4);
    $display("pseudo frame done");
    pulse(22'h00_0001);
    @(posedge clk_sys) rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    rd();
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    $display("reset done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

//--- sim/usbis_host.sv
// processor model making status register accesses
`timescale 1ns/100ps
`default_nettype none
module usbis_host
  import usbis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [31:0] rdata,
  output var usbis_pkg::usbis_bus_s bus
);
  initial bus = '0;
  // one-cycle strobe, reserved bits 31..26 always written as zero
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys) bus <= '{1'b1, w, a, d & 32'h03FF_FFFF};
    @(posedge clk_sys) bus <= '0;
    #1 q = rdata;
  endtask : acc
endmodule : usbis_host
`default_nettype wire

//--- sim/usbis_monitor.sv
// port assertions for the interrupt status block
`timescale 1ns/100ps
`default_nettype none
module usbis_monitor
  import usbis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire usbis_pkg::usbis_bus_s bus,
  input wire logic [31:0] rdata,
  input wire usbis_pkg::usbis_event_s evt,
  input wire logic [15:0] dma_status,
  input wire logic dma_reason_clear,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic rd;
  logic wr;
  // decoded strobes; other addresses must not count
  assign rd = bus.sel && !bus.wr && bus.addr == USBIS_ADDR_STATUS;
  assign wr = bus.sel && bus.wr && bus.addr == USBIS_ADDR_STATUS;
  AST_RSV: assert property ((rdata & ~USBIS_IMPL_MASK) == 32'h0)
    else $error("reserved bit read high");
  AST_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  AST_EVT_IRQ: assert property ((|evt.ep_transmit) |=> irq)
    else $error("event without irq");
  AST_SETUP: assert property (rd && evt.setup_received |=> rdata[8])
    else $error("setup flag missing");
  AST_EP: assert property (rd && evt.ep_receive[0] |=> rdata[10])
    else $error("endpoint flag missing");
  AST_HS: assert property (rd && $rose(evt.high_speed) |=> rdata[5])
    else $error("speed flag missing");
  AST_DMA: assert property ($changed(dma_status) |-> ##[1:2] irq)
    else $error("dma change lost");
  AST_KEEP: assert property (wr && evt.resume |=> irq)
    else $error("event lost to clear");
  AST_ZERO: assert property (wr && bus.wdata == 32'h0 && irq && !dma_reason_clear |=> irq)
    else $error("zero write cleared");
  cover property (rd && evt.frame_marker);
  cover property (wr && evt.resume);
  cover property (dma_reason_clear && irq);
  cover property (evt.frame_marker && evt.high_speed);
endmodule : usbis_monitor
bind usbis_top usbis_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
  .evt(evt), .dma_status(dma_status), .dma_reason_clear(dma_reason_clear), .irq(irq));
`default_nettype wire
